// file: rtl/counter_array_watchdog.sv
// Watchdog built on module five of the 16-bit counter array, with its shared control flags.
// Summary of operation
// RULE1 - While guarding, compare high byte is matched against counter high byte.
// RULE2 - Offset counts low-byte overflows; first overflow takes up to 256 ticks.
// RULE3 - Timeout is 256 times offset plus 256 minus low byte at reload.
// RULE4 - Low-byte overflow while compare high equals counter high raises reset.
// RULE5 - Writing one to module five match flag while guarding forces reset.
// RULE6 - Software disables, picks clock, loads offset, idle, enables, then reloads.
// RULE7 - Clock selection and idle suspend are frozen while guarding.
// RULE8 - Enable bit or lock bit set makes the watchdog active.
// RULE9 - Lock keeps watchdog active, refusing disable until next system reset.
// RULE10 - With lock clear, clearing enable bit deactivates the watchdog.
// RULE11 - After reset: active, clock divided by 12, low byte and offset zero.
// RULE12 - Overflow flag bit 7 sets on 16-bit wrap, requests interrupt, software clears.
// RULE13 - Bit 6 is run control enabling counting of the 16-bit counter.
// RULE14 - Match flags set on match or capture, request interrupt, never hardware-cleared.
// RULE15 - Any compare high write while guarding reloads it with counter high plus offset.
// RULE16 - Guarding forces counter on, blocks counter writes and module five mode writes.
// RULE17 - Guarding ignores run-control effect; run control reads software's own value.
// RULE18 - Reset request is one system-clock pulse; reset logic restores defaults.
`timescale 1ns/10ps
`default_nettype none
module counter_array_watchdog (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Special function register port
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_we,
  input wire logic sfr_re,
  output logic [7:0] sfr_rdata,
  // Surroundings
  input wire logic cpu_idle,
  input wire logic ext_tick,
  input wire logic [4:0] module_match_events,
  input wire logic [5:0] match_irq_enable,
  // Requests
  output logic overflow_irq,
  output logic match_irq,
  output logic wdt_reset_req
);
  logic [15:0] counter;
  logic [7:0] wdt_reload_offset;
  logic [7:0] wdt_compare_high;
  logic [7:0] module_five_mode_register;
  logic counter_overflow_flag;
  logic counter_run_control;
  logic [5:0] match_flags;
  logic watchdog_enable_bit;
  logic watchdog_lock_bit;
  logic idle_suspend_select;
  logic [2:0] counter_clock_select;
  logic overflow_irq_enable;
  logic tick;

  wire wdt_active = watchdog_enable_bit | watchdog_lock_bit; // [RULE8]
  wire wr_control = sfr_we && sfr_addr == counter_array_watchdog_pkg::REG_CONTROL_FLAGS;
  wire wr_mode = sfr_we && sfr_addr == counter_array_watchdog_pkg::REG_ARRAY_MODE;
  wire wr_low = sfr_we && sfr_addr == counter_array_watchdog_pkg::REG_COUNTER_LOW;
  wire wr_high = sfr_we && sfr_addr == counter_array_watchdog_pkg::REG_COUNTER_HIGH;
  wire wr_m5_mode = sfr_we && sfr_addr == counter_array_watchdog_pkg::REG_MODULE_FIVE_MODE;
  wire wr_offset = sfr_we && sfr_addr == counter_array_watchdog_pkg::REG_WDT_RELOAD_OFFSET;
  wire wr_cmp_high = sfr_we && sfr_addr == counter_array_watchdog_pkg::REG_WDT_COMPARE_HIGH;

  counter_clock_tick clock_gen (
    .core_clk(core_clk),
    .rst(rst),
    .clock_select(counter_clock_select),
    .ext_tick(ext_tick),
    .tick(tick)
  );

  // Guarding forces the counter on regardless of run control; idle suspend still applies.
  wire run_en = (counter_run_control | wdt_active) &
    ~(idle_suspend_select & cpu_idle); // [RULE13] [RULE16] [RULE17]
  wire count_step = tick & run_en;
  wire low_ovf = count_step && counter[7:0] == 8'hFF; // [RULE2]
  wire full_wrap = count_step && counter == 16'hFFFF;
  wire wdt_match = wdt_compare_high == counter[15:8]; // [RULE1]
  // Reaching the trip therefore takes 256*offset plus (256 - low byte at reload) ticks.
  wire wdt_expire = wdt_active & low_ovf & wdt_match; // [RULE3] [RULE4]
  wire wdt_force = wdt_active & wr_control &
    sfr_wdata[counter_array_watchdog_pkg::MATCH_FIVE_BIT]; // [RULE5]
  wire wdt_trip = wdt_expire | wdt_force;
  wire [7:0] reload_value = 8'(counter[15:8] + wdt_reload_offset); // [RULE15]
  wire module_five_hit = wdt_active && count_step &&
    counter == {wdt_compare_high, wdt_reload_offset};
  wire [5:0] match_set = {module_five_hit, module_match_events};

  // Counter writes are dropped while guarding so software cannot postpone the trip.
  wire [15:0] next_counter = (wr_low && !wdt_active) ? {counter[15:8], sfr_wdata} :
    (wr_high && !wdt_active) ? {sfr_wdata, counter[7:0]} :
    count_step ? 16'(counter + 16'h0001) : counter; // [RULE16]
  wire [7:0] next_compare_high = !wr_cmp_high ? wdt_compare_high :
    wdt_active ? reload_value : sfr_wdata; // [RULE15]
  // Hardware set wins over a software clear arriving in the same cycle.
  wire next_cf = full_wrap | (wr_control ? sfr_wdata[counter_array_watchdog_pkg::CF_BIT] :
    counter_overflow_flag); // [RULE12]
  wire [5:0] next_match_flags = match_set |
    (wr_control ? sfr_wdata[5:0] : match_flags); // [RULE14]
  wire next_lock = watchdog_lock_bit |
    (wr_mode & sfr_wdata[counter_array_watchdog_pkg::LOCK_BIT]); // [RULE9]
  wire next_enable = !wr_mode ? watchdog_enable_bit :
    watchdog_lock_bit ? 1'b1 : sfr_wdata[counter_array_watchdog_pkg::ENABLE_BIT]; // [RULE9] [RULE10]
  wire next_idle = (wr_mode && !wdt_active) ?
    sfr_wdata[counter_array_watchdog_pkg::IDLE_SUSPEND_BIT] : idle_suspend_select; // [RULE7]
  wire [2:0] next_clock_select = (wr_mode && !wdt_active) ?
    sfr_wdata[counter_array_watchdog_pkg::CLOCK_SEL_MSB:
      counter_array_watchdog_pkg::CLOCK_SEL_LSB] :
    counter_clock_select; // [RULE7]

  wire [7:0] mode_view = {idle_suspend_select, watchdog_enable_bit, watchdog_lock_bit, 1'b0,
    counter_clock_select, overflow_irq_enable};
  wire [7:0] read_mux =
    (sfr_addr == counter_array_watchdog_pkg::REG_CONTROL_FLAGS) ?
      {counter_overflow_flag, counter_run_control, match_flags} : // [RULE17]
    (sfr_addr == counter_array_watchdog_pkg::REG_ARRAY_MODE) ? mode_view :
    (sfr_addr == counter_array_watchdog_pkg::REG_COUNTER_LOW) ? counter[7:0] :
    (sfr_addr == counter_array_watchdog_pkg::REG_COUNTER_HIGH) ? counter[15:8] :
    (sfr_addr == counter_array_watchdog_pkg::REG_MODULE_FIVE_MODE) ?
      (wdt_active ? counter_array_watchdog_pkg::SOFTWARE_TIMER_MODE :
       module_five_mode_register) : // [RULE16]
    (sfr_addr == counter_array_watchdog_pkg::REG_WDT_RELOAD_OFFSET) ? wdt_reload_offset :
    (sfr_addr == counter_array_watchdog_pkg::REG_WDT_COMPARE_HIGH) ? wdt_compare_high :
    8'h00;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      counter <= counter_array_watchdog_pkg::COUNTER_RESET; // [RULE11]
      wdt_reload_offset <= counter_array_watchdog_pkg::OFFSET_RESET;
      wdt_compare_high <= counter_array_watchdog_pkg::COMPARE_HIGH_RESET;
      module_five_mode_register <= counter_array_watchdog_pkg::MODULE_FIVE_MODE_RESET;
      counter_overflow_flag <= 1'b0;
      counter_run_control <= 1'b0;
      match_flags <= 6'h00;
      watchdog_enable_bit <= 1'b1;
      watchdog_lock_bit <= 1'b0;
      idle_suspend_select <= 1'b0;
      counter_clock_select <= counter_array_watchdog_pkg::CLOCK_SEL_RESET;
      overflow_irq_enable <= 1'b0;
      sfr_rdata <= 8'h00;
      wdt_reset_req <= 1'b0;
    end else begin
      counter <= next_counter;
      wdt_reload_offset <= wr_offset ? sfr_wdata : wdt_reload_offset;
      wdt_compare_high <= next_compare_high;
      module_five_mode_register <= (wr_m5_mode && !wdt_active) ? sfr_wdata :
        module_five_mode_register; // [RULE16]
      counter_overflow_flag <= next_cf;
      counter_run_control <= wr_control ? sfr_wdata[counter_array_watchdog_pkg::CR_BIT] :
        counter_run_control; // [RULE13]
      match_flags <= next_match_flags;
      watchdog_enable_bit <= next_enable;
      watchdog_lock_bit <= next_lock;
      idle_suspend_select <= next_idle;
      counter_clock_select <= next_clock_select;
      overflow_irq_enable <= wr_mode ? sfr_wdata[counter_array_watchdog_pkg::OVF_IRQ_EN_BIT] :
        overflow_irq_enable;
      sfr_rdata <= sfr_re ? read_mux : sfr_rdata;
      wdt_reset_req <= wdt_trip; // [RULE18]
    end
  end

  assign overflow_irq = counter_overflow_flag & overflow_irq_enable; // [RULE12]
  assign match_irq = |(match_flags & match_irq_enable); // [RULE14]

  property p_expire_reset;
    @(posedge core_clk) disable iff (rst)
    wdt_active && low_ovf && wdt_compare_high == counter[15:8] |=> wdt_reset_req;
  endproperty
  a_expire_reset: assert property (p_expire_reset) else $error("expiry gave no reset"); // [RULE4]

  property p_force_reset;
    @(posedge core_clk) disable iff (rst)
    wdt_active && wr_control && sfr_wdata[5] |=> wdt_reset_req;
  endproperty
  a_force_reset: assert property (p_force_reset) else $error("forced reset missing"); // [RULE5]

  property p_no_spurious_reset;
    @(posedge core_clk) disable iff (rst)
    wdt_reset_req |-> $past(wdt_active) &&
      ($past(low_ovf && wdt_compare_high == counter[15:8]) ||
       $past(wr_control && sfr_wdata[5]));
  endproperty
  a_no_spurious_reset: assert property (p_no_spurious_reset) // [RULE18]
    else $error("spurious reset");

  property p_reload;
    @(posedge core_clk) disable iff (rst)
    wdt_active && wr_cmp_high |=>
      wdt_compare_high == 8'($past(counter[15:8]) + $past(wdt_reload_offset));
  endproperty
  a_reload: assert property (p_reload) else $error("reload value wrong"); // [RULE15]

  property p_lock_holds;
    @(posedge core_clk) disable iff (rst)
    watchdog_lock_bit |=> watchdog_lock_bit && wdt_active;
  endproperty
  a_lock_holds: assert property (p_lock_holds) else $error("lock released"); // [RULE9]

  property p_disable;
    @(posedge core_clk) disable iff (rst)
    !watchdog_lock_bit && wr_mode && !sfr_wdata[6] && !sfr_wdata[5] |=> !wdt_active;
  endproperty
  a_disable: assert property (p_disable) else $error("disable ignored"); // [RULE10]

  property p_frozen_select;
    @(posedge core_clk) disable iff (rst)
    wdt_active |=> $stable(counter_clock_select) && $stable(idle_suspend_select);
  endproperty
  a_frozen_select: assert property (p_frozen_select) else $error("select changed"); // [RULE7]

  property p_counter_forced;
    @(posedge core_clk) disable iff (rst)
    wdt_active && tick && !(idle_suspend_select && cpu_idle) |=>
      counter == 16'($past(counter) + 16'h0001);
  endproperty
  a_counter_forced: assert property (p_counter_forced) // [RULE16]
    else $error("counter not forced");

  property p_wrap_flag;
    @(posedge core_clk) disable iff (rst)
    full_wrap |=> counter_overflow_flag && counter == 16'h0000;
  endproperty
  a_wrap_flag: assert property (p_wrap_flag) else $error("overflow flag missed"); // [RULE12]

  property p_defaults;
    @(posedge core_clk)
    rst |=> wdt_active && counter == 16'h0000 && wdt_reload_offset == 8'h00 &&
      counter_clock_select == 3'h0;
  endproperty
  a_defaults: assert property (p_defaults) else $error("reset defaults wrong"); // [RULE11]

  property p_run_read;
    @(posedge core_clk) disable iff (rst)
    sfr_re && !sfr_we && sfr_addr == 8'hD8 && !counter_run_control |=> !sfr_rdata[6];
  endproperty
  a_run_read: assert property (p_run_read) else $error("run control misread"); // [RULE17]
endmodule : counter_array_watchdog
`default_nettype wire

// file: rtl/counter_array_watchdog_pkg.sv
// Constants shared by the counter array watchdog and its counter clock generator.
package counter_array_watchdog_pkg;
  // Register indices on the special function register port.
  localparam logic [7:0] REG_CONTROL_FLAGS = 8'hD8;
  localparam logic [7:0] REG_ARRAY_MODE = 8'hD9;
  localparam logic [7:0] REG_COUNTER_LOW = 8'hF9;
  localparam logic [7:0] REG_COUNTER_HIGH = 8'hFA;
  localparam logic [7:0] REG_MODULE_FIVE_MODE = 8'hDE;
  localparam logic [7:0] REG_WDT_RELOAD_OFFSET = 8'hD3;
  localparam logic [7:0] REG_WDT_COMPARE_HIGH = 8'hD4;
  // Control flag register field positions.
  localparam int CF_BIT = 7;
  localparam int CR_BIT = 6;
  localparam int MATCH_FIVE_BIT = 5;
  // Array mode register field positions.
  localparam int IDLE_SUSPEND_BIT = 7;
  localparam int ENABLE_BIT = 6;
  localparam int LOCK_BIT = 5;
  localparam int CLOCK_SEL_MSB = 3;
  localparam int CLOCK_SEL_LSB = 1;
  localparam int OVF_IRQ_EN_BIT = 0;
  // Values after reset.
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [15:0] COUNTER_RESET = 16'h0000;
  localparam logic [7:0] OFFSET_RESET = 8'h00;
  localparam logic [7:0] COMPARE_HIGH_RESET = 8'h00;
  localparam logic [7:0] MODULE_FIVE_MODE_RESET = 8'h00;
  localparam logic [2:0] CLOCK_SEL_RESET = 3'h0;
  // Software timer mode as seen in the module five mode register while guarding.
  localparam logic [7:0] SOFTWARE_TIMER_MODE = 8'h48;
  // Counter clock selections.
  localparam logic [2:0] CLK_SYS_DIV12 = 3'h0;
  localparam logic [2:0] CLK_SYS_DIV4 = 3'h1;
  localparam logic [2:0] CLK_SYS = 3'h4;
  localparam int DIV12_COUNT = 12;
  localparam int DIV4_COUNT = 4;
  localparam logic [3:0] DIVIDER_RESET = 4'h0;
endpackage : counter_array_watchdog_pkg

// file: rtl/counter_clock_tick.sv
// Counter clock enable generator: turns the clock selection into one-cycle ticks.
`timescale 1ns/10ps
`default_nettype none
module counter_clock_tick (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Selection and external source
  input wire logic [2:0] clock_select,
  input wire logic ext_tick,
  // Tick out
  output logic tick
);
  logic [3:0] divider;
  logic [3:0] next_divider;
  logic [3:0] divide_last;
  logic next_tick;

  assign divide_last = (clock_select == counter_array_watchdog_pkg::CLK_SYS_DIV4) ?
    4'(counter_array_watchdog_pkg::DIV4_COUNT - 1) :
    4'(counter_array_watchdog_pkg::DIV12_COUNT - 1);
  assign next_divider = (divider >= divide_last) ? counter_array_watchdog_pkg::DIVIDER_RESET :
    4'(divider + 4'h1);

  // Selections other than the divided or undivided system clock follow the external tick input.
  assign next_tick = (clock_select == counter_array_watchdog_pkg::CLK_SYS) ? 1'b1 :
    (clock_select == counter_array_watchdog_pkg::CLK_SYS_DIV12 ||
     clock_select == counter_array_watchdog_pkg::CLK_SYS_DIV4) ? (divider >= divide_last) :
    ext_tick;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      divider <= counter_array_watchdog_pkg::DIVIDER_RESET;
      tick <= 1'b0;
    end else begin
      divider <= next_divider;
      tick <= next_tick;
    end
  end
endmodule : counter_clock_tick
`default_nettype wire

// file: tb/reset_logic_model.sv
// Model of the system reset logic that answers the watchdog reset request.
`timescale 1ns/10ps
`default_nettype none
module reset_logic_model #(
  parameter int HOLD = 4
) (
  // Clock and request
  input wire logic core_clk,
  input wire logic reset_req,
  // Reset back to the block
  output logic sys_rst
);
  int left = 0;
  // A new request restarts the hold, so a repeated pulse is never lost.
  always_ff @(posedge core_clk) begin
    if (reset_req)
      left <= HOLD;
    else if (left > 0)
      left <= left - 1;
  end
  assign sys_rst = (left > 0);
endmodule : reset_logic_model
`default_nettype wire

// file: tb/test_counter_array_watchdog.sv
// Self-checking bench for the counter array watchdog.
`timescale 1ns/10ps
`default_nettype none
module test_counter_array_watchdog;
  logic core_clk = 0, bench_rst = 1, sfr_we = 0, sfr_re = 0, cpu_idle = 0, ext_tick = 0;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, v;
  logic [4:0] module_match_events = 5'h00;
  logic [5:0] match_irq_enable = 6'h00;
  logic overflow_irq, match_irq, wdt_reset_req, sys_rst, rst;
  int bad_count = 0, num_checks = 0, cyc = 0, cyc_at = 0, t0 = 0, n;
  typedef struct {logic [7:0] addr; logic [7:0] exp;} row_t;
  // The unmapped index 0x77 closes the table.
  row_t rows [7] = '{'{8'hF9, 8'h00}, '{8'hD3, 8'h00}, '{8'hD4, 8'h00}, '{8'hD8, 8'h00},
                     '{8'hDE, 8'h48}, '{8'hD9, 8'h40}, '{8'h77, 8'h00}};
  assign rst = bench_rst | sys_rst;
  counter_array_watchdog counter_array_watchdog_i (.core_clk(core_clk), .rst(rst),
    .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_we(sfr_we), .sfr_re(sfr_re),
    .sfr_rdata(sfr_rdata), .cpu_idle(cpu_idle), .ext_tick(ext_tick),
    .module_match_events(module_match_events), .match_irq_enable(match_irq_enable),
    .overflow_irq(overflow_irq), .match_irq(match_irq), .wdt_reset_req(wdt_reset_req));
  reset_logic_model reset_logic_model_i (.core_clk(core_clk), .reset_req(wdt_reset_req),
    .sys_rst(sys_rst));
  initial forever #2.5 core_clk = ~core_clk;
  always @(posedge core_clk) cyc <= rst ? 0 : cyc + 1;
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL %0t %s: saw %h want %h", $time, what, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk) #1;
    sfr_we = 1;
    sfr_addr = a;
    sfr_wdata = d;
    @(posedge core_clk) #1;
    sfr_we = 0;
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge core_clk) #1;
    sfr_re = 1;
    sfr_addr = a;
    @(posedge core_clk) #1;
    sfr_re = 0;
    v = sfr_rdata;
    chk(v, exp, what);
  endtask : rc
  // Waits for the reset request, checks it is one cycle wide, then rides out the reset.
  task automatic pulse(input int lim);
    n = 0;
    while (wdt_reset_req !== 1'b1 && n < lim) begin
      @(posedge core_clk) #1;
      n++;
    end
    cyc_at = cyc;
    chk({7'h00, wdt_reset_req}, 8'h01, "reset request");
    @(posedge core_clk) #1;
    chk({7'h00, wdt_reset_req}, 8'h00, "request width");
    while (rst) begin
      @(posedge core_clk) #1;
    end
  endtask : pulse
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (20) @(posedge core_clk);
    #1 bench_rst = 0;
    foreach (rows[i]) rc(rows[i].addr, rows[i].exp, "reset value");
    pulse(5000);
    chk(8'(cyc_at inside {[3072:3084]}), 8'h01, "default timeout");
    $display("test defaults done");
    wr(8'hD9, 8'h00);
    wr(8'hD9, 8'h08);
    wr(8'hFA, 8'h00);
    wr(8'hF9, 8'h00);
    wr(8'hD3, 8'h02);
    wr(8'hD9, 8'h48);
    wr(8'hD4, 8'hA5);
    t0 = cyc;
    rc(8'hD4, 8'h02, "reload value");
    wr(8'hFA, 8'h55);
    rc(8'hFA, 8'h00, "counter write blocked");
    wr(8'hDE, 8'h00);
    rc(8'hDE, 8'h48, "module five mode held");
    wr(8'hD9, 8'h40);
    rc(8'hD9, 8'h48, "clock select frozen");
    pulse(1000);
    chk(8'((cyc_at - t0) inside {[760:772]}), 8'h01, "offset timeout");
    $display("test offset timeout done");
    wr(8'hD9, 8'h00);
    rc(8'hD9, 8'h00, "disabled");
    rc(8'hDE, 8'h00, "mode released");
    wr(8'hD8, 8'h20);
    chk({7'h00, wdt_reset_req}, 8'h00, "no force when idle");
    wr(8'hD8, 8'h00);
    wr(8'hD9, 8'h20);
    rc(8'hDE, 8'h48, "lock activates");
    wr(8'hD9, 8'h00);
    rc(8'hD9, 8'h60, "lock holds");
    rc(8'hDE, 8'h48, "still active");
    wr(8'hD8, 8'h20);
    chk({7'h00, wdt_reset_req}, 8'h01, "forced reset");
    pulse(4);
    $display("test lock and force done");
    wr(8'hD9, 8'h00);
    wr(8'hD9, 8'h89);
    wr(8'hFA, 8'hFF);
    wr(8'hF9, 8'hFE);
    wr(8'hD8, 8'h40);
    repeat (6) @(posedge core_clk);
    rc(8'hD8, 8'hC0, "wrap flag");
    chk({7'h00, overflow_irq}, 8'h01, "overflow irq");
    wr(8'hD8, 8'h00);
    // Ten steps from 0xFFFE: run control is taken one edge late and dropped one edge late.
    rc(8'hF9, 8'h08, "counter low");
    t0 = v;
    rc(8'hF9, t0[7:0], "counter stopped");
    cpu_idle = 1;
    wr(8'hD8, 8'h40);
    repeat (4) @(posedge core_clk);
    rc(8'hF9, t0[7:0], "idle suspends count");
    wr(8'hD8, 8'h00);
    cpu_idle = 0;
    match_irq_enable = 6'h10;
    @(posedge core_clk) #1;
    module_match_events = 5'h10;
    @(posedge core_clk) #1;
    module_match_events = 5'h00;
    repeat (4) @(posedge core_clk);
    rc(8'hD8, 8'h10, "match flag kept");
    chk({7'h00, match_irq}, 8'h01, "match irq");
    $display("test flags done");
    tally_and_finish();
  end
  initial begin
    #60000;
    bad_count++;
    $display("FAIL %0t run did not finish", $time);
    tally_and_finish();
  end
endmodule : test_counter_array_watchdog
`default_nettype wire
